// >>> inc/bco_pkg.sv
// Shared types and constants for the barrier ordering unit
package bco_pkg;

  localparam int ADDR_W = 32;
  localparam int ID_W   = 4;
  localparam int DATA_W = 32;
  localparam int CNT_W  = 8;
  localparam int REG_AW = 8;

  // Address-channel field positions and encodings
  localparam int       BAR_BIT       = 0;
  localparam int       BAR_SYNC_BIT  = 1;
  localparam int       CACHE_MOD_BIT = 1;
  localparam logic [1:0] DOM_SYSTEM  = 2'h3;
  localparam int       REGION_BITS   = 12;

  // Barrier response: single beat, no data
  localparam logic [3:0]        BAR_RRESP = 4'h0;
  localparam logic [1:0]        BAR_BRESP = 2'h0;
  localparam logic [DATA_W-1:0] BAR_RDATA = 32'h0000_0000;

  // Register map
  localparam logic [REG_AW-1:0] REG_CTRL   = 8'h00;
  localparam logic [REG_AW-1:0] REG_STATUS = 8'h04;
  localparam logic [REG_AW-1:0] REG_BARCNT = 8'h08;
  localparam logic [REG_AW-1:0] REG_CROSS  = 8'h0c;
  localparam logic [REG_AW-1:0] REG_MODCNT = 8'h10;
  localparam int   CTRL_DRAIN_MEM_BIT = 0;
  localparam logic CTRL_DRAIN_MEM_RST = 1'b0;
  localparam int   STATUS_WR_LSB      = 8;
  localparam int   STATUS_BUSY_BIT    = 16;
  localparam logic [DATA_W-1:0] REG_UNMAPPED = 32'h0000_0000;

  typedef struct packed {
    logic [ID_W-1:0]   id;
    logic [ADDR_W-1:0] addr;
    logic [7:0]        len;
    logic [2:0]        size;
    logic [1:0]        burst;
    logic [3:0]        cache;
    logic [3:0]        snoop;
    logic [1:0]        domain;
    logic [1:0]        bar;
  } bco_ar_t;

  typedef struct packed {
    logic [ID_W-1:0]   id;
    logic [ADDR_W-1:0] addr;
    logic [7:0]        len;
    logic [2:0]        size;
    logic [1:0]        burst;
    logic [3:0]        cache;
    logic [2:0]        snoop;
    logic [1:0]        domain;
    logic [1:0]        bar;
    logic              keep_unique;
  } bco_aw_t;

  typedef struct packed {
    logic [DATA_W-1:0]   data;
    logic [DATA_W/8-1:0] strb;
    logic                last;
  } bco_w_t;

  typedef struct packed {
    logic [ID_W-1:0]   id;
    logic [DATA_W-1:0] data;
    logic [3:0]        resp;
    logic              last;
  } bco_r_t;

  typedef struct packed {
    logic [ID_W-1:0] id;
    logic [1:0]      resp;
  } bco_b_t;

  typedef enum logic [1:0] {
    ST_IDLE,
    ST_PAIR,
    ST_DRAIN,
    ST_RESP
  } bco_st_t;

  typedef struct packed {
    bco_st_t           st;
    logic              drain_mem;
    logic [ID_W-1:0]   bar_id;
    logic              bar_sync;
    logic [1:0]        bar_dom;
    logic              got_ar;
    logic              got_aw;
    logic              r_pend;
    logic              b_pend;
    logic              r_show;
    logic              b_show;
    logic              r_mid;
    logic [15:0]       bar_cnt;
    logic [15:0]       cross_cnt;
    logic [15:0]       mod_cnt;
    logic [DATA_W-1:0] rdata;
  } bco_state_t;

endpackage

// >>> logic/bco_cnt.sv
// Outstanding transaction counter
`timescale 1ns/100ps
module bco_cnt (
  input  wire logic                     clk,
  input  wire logic                     nrst,
  input  wire logic                     inc,
  input  wire logic                     dec,
  output logic [bco_pkg::CNT_W-1:0]     count,
  output logic                          zero
);

  logic [bco_pkg::CNT_W-1:0] cnt_r;
  logic [bco_pkg::CNT_W-1:0] cnt_nxt;

  // Simultaneous inc and dec cancel out
  always_comb begin
    cnt_nxt = cnt_r;
    if (inc && !dec) begin
      cnt_nxt = cnt_r + 1'b1;
    end else if (dec && !inc) begin
      cnt_nxt = cnt_r - 1'b1;
    end
  end

  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      cnt_r <= '0;
    end else begin
      cnt_r <= cnt_nxt;
    end
  end

  assign count = cnt_r;
  assign zero  = (cnt_r == '0);

endmodule

// >>> logic/bco_barrier_unit.sv
// Barrier ordering and coherency field pass-through for one master port
//
// Functional notes
// - Barriers have address phase and response only, never data beats.
// - After memory barrier, later observers also see all earlier transactions.
// - Sync barrier answered only once earlier transactions are observable.
// - System-domain sync barrier waits until earlier transactions reach slaves.
// - Mismatched attributes must never deadlock; transactions keep progressing.
// - Corruption from mismatched attributes stays within its 4KB region.
// - Modifiable accesses to peripherals still get protocol-compliant responses.
// - Interconnect drives the two extra read response bits.
// - Write data and write response channels carry no added signals.
// - During reset acknowledges and snoop valids are held low.
//
// The placing of the registers and strobed register access are this design's own decisions.
`timescale 1ns/100ps
module bco_barrier_unit (
  input  wire logic                          clk,
  input  wire logic                          nrst,
  // Master side
  input  wire logic                          m_ar_valid,
  output logic                               m_ar_ready,
  input  wire bco_pkg::bco_ar_t              m_ar,
  input  wire logic                          m_aw_valid,
  output logic                               m_aw_ready,
  input  wire bco_pkg::bco_aw_t              m_aw,
  input  wire logic                          m_w_valid,
  output logic                               m_w_ready,
  input  wire bco_pkg::bco_w_t               m_w,
  output logic                               m_r_valid,
  input  wire logic                          m_r_ready,
  output bco_pkg::bco_r_t                    m_r,
  output logic                               m_b_valid,
  input  wire logic                          m_b_ready,
  output bco_pkg::bco_b_t                    m_b,
  output logic                               ac_valid,
  // Downstream side
  output logic                               s_ar_valid,
  input  wire logic                          s_ar_ready,
  output bco_pkg::bco_ar_t                   s_ar,
  output logic                               s_aw_valid,
  input  wire logic                          s_aw_ready,
  output bco_pkg::bco_aw_t                   s_aw,
  output logic                               s_w_valid,
  input  wire logic                          s_w_ready,
  output bco_pkg::bco_w_t                    s_w,
  input  wire logic                          s_r_valid,
  output logic                               s_r_ready,
  input  wire bco_pkg::bco_r_t               s_r,
  input  wire logic                          s_b_valid,
  output logic                               s_b_ready,
  input  wire bco_pkg::bco_b_t               s_b,
  // Register port
  input  wire logic [bco_pkg::REG_AW-1:0]    reg_addr,
  input  wire logic [bco_pkg::DATA_W-1:0]    reg_wdata,
  input  wire logic                          reg_wr,
  input  wire logic                          reg_rd,
  output logic [bco_pkg::DATA_W-1:0]         reg_rdata
);

  bco_pkg::bco_state_t st_r;
  bco_pkg::bco_state_t st_nxt;

  logic                      idle;
  logic                      half_ok;
  logic                      ar_bar;
  logic                      aw_bar;
  logic                      ar_bar_take;
  logic                      aw_bar_take;
  logic                      ar_fwd;
  logic                      aw_fwd;
  logic                      r_done;
  logic                      b_done;
  logic                      bar_r_go;
  logic                      bar_b_go;
  logic                      drain_ok;
  logic [bco_pkg::CNT_W-1:0] rd_cnt;
  logic [bco_pkg::CNT_W-1:0] wr_cnt;
  logic                      rd_zero;
  logic                      wr_zero;
  bco_pkg::bco_r_t           bar_r;
  bco_pkg::bco_b_t           bar_b;

  // True when a burst leaves its 4KB region
  function automatic logic crosses_4k(input logic [bco_pkg::ADDR_W-1:0] addr,
                                      input logic [7:0] len,
                                      input logic [2:0] size);
    logic [16:0] last_byte;
    last_byte = {5'h00, addr[bco_pkg::REGION_BITS-1:0]}
              + 17'(({9'h000, len} + 17'h0_0001) << size) - 17'h0_0001;
    return last_byte[16:bco_pkg::REGION_BITS] != '0;
  endfunction

  assign idle    = (st_r.st == bco_pkg::ST_IDLE);
  assign half_ok = idle || (st_r.st == bco_pkg::ST_PAIR);
  assign ar_bar  = m_ar.bar[bco_pkg::BAR_BIT];
  assign aw_bar  = m_aw.bar[bco_pkg::BAR_BIT];

  // Barriers end here and never reach the address channels downstream
  assign s_ar_valid = m_ar_valid && !ar_bar && idle;
  assign s_aw_valid = m_aw_valid && !aw_bar && idle;
  // Coherency fields pass unchanged
  // Address never rewritten; bursts that cross a 4KB region go out as they are and are only counted, a read and a write crossing in one cycle as one
  assign s_ar = m_ar;
  assign s_aw = m_aw;

  // Ordinary traffic stalls while a barrier is open
  assign m_ar_ready = ar_bar ? (half_ok && !st_r.got_ar) : (s_ar_ready && idle);
  assign m_aw_ready = aw_bar ? (half_ok && !st_r.got_aw) : (s_aw_ready && idle);

  assign ar_bar_take = m_ar_valid && ar_bar && half_ok && !st_r.got_ar;
  assign aw_bar_take = m_aw_valid && aw_bar && half_ok && !st_r.got_aw;
  assign ar_fwd      = s_ar_valid && s_ar_ready;
  assign aw_fwd      = s_aw_valid && s_aw_ready;

  // Stray barrier write beats are not filtered; they reach the endpoint
  // Write data and write response carry no added fields
  assign s_w_valid = m_w_valid;
  assign m_w_ready = s_w_ready;
  assign s_w       = m_w;

  // Barrier read answer is one response beat with no payload
  assign bar_r.id   = st_r.bar_id;
  assign bar_r.data = bco_pkg::BAR_RDATA;
  assign bar_r.resp = bco_pkg::BAR_RRESP;
  assign bar_r.last = 1'b1;
  assign bar_b.id   = st_r.bar_id;
  assign bar_b.resp = bco_pkg::BAR_BRESP;

  // Waiting for a gap trades barrier latency for intact bursts
  // Slot in only between bursts; once shown, hold until taken
  assign bar_r_go = st_r.r_pend && !st_r.r_mid && (st_r.r_show || !s_r_valid);
  assign bar_b_go = st_r.b_pend && (st_r.b_show || !s_b_valid);

  // Full four-bit read response passes through
  assign m_r_valid = bar_r_go || s_r_valid;
  assign m_r       = bar_r_go ? bar_r : s_r;
  assign s_r_ready = m_r_ready && !bar_r_go;
  assign m_b_valid = bar_b_go || s_b_valid;
  assign m_b       = bar_b_go ? bar_b : s_b;
  assign s_b_ready = m_b_ready && !bar_b_go;

  assign r_done = s_r_valid && s_r_ready && s_r.last;
  assign b_done = s_b_valid && s_b_ready;

  // No snoops issued here; held low from reset on
  assign ac_valid = 1'b0;

  // Trackers wrap past 255 outstanding; deeper masters are not guarded
  bco_cnt u_rd_cnt (
    .clk   (clk),
    .nrst  (nrst),
    .inc   (ar_fwd),
    .dec   (r_done),
    .count (rd_cnt),
    .zero  (rd_zero)
  );

  bco_cnt u_wr_cnt (
    .clk   (clk),
    .nrst  (nrst),
    .inc   (aw_fwd),
    .dec   (b_done),
    .count (wr_cnt),
    .zero  (wr_zero)
  );

  // Sync barriers wait for every earlier response from the endpoint
  // Memory barriers rely on the stall unless software asks for a full drain
  assign drain_ok = (st_r.bar_sync || st_r.drain_mem) ? (rd_zero && wr_zero) : 1'b1;

  always_comb begin
    st_nxt = st_r;
    st_nxt.rdata = '0;
    // Burst tracking keeps barrier beats out of a running read burst
    if (s_r_valid && s_r_ready) begin
      st_nxt.r_mid = !s_r.last;
    end
    st_nxt.r_show = bar_r_go && !m_r_ready;
    st_nxt.b_show = bar_b_go && !m_b_ready;
    if (ar_fwd && crosses_4k(m_ar.addr, m_ar.len, m_ar.size)) begin
      st_nxt.cross_cnt = st_r.cross_cnt + 16'h0001;
    end else if (aw_fwd && crosses_4k(m_aw.addr, m_aw.len, m_aw.size)) begin
      st_nxt.cross_cnt = st_r.cross_cnt + 16'h0001;
    end
    // Modifiable accesses are forwarded and answered as usual
    if ((ar_fwd && m_ar.cache[bco_pkg::CACHE_MOD_BIT])
        || (aw_fwd && m_aw.cache[bco_pkg::CACHE_MOD_BIT])) begin
      st_nxt.mod_cnt = st_r.mod_cnt + 16'h0001;
    end

    case (st_r.st)
      bco_pkg::ST_IDLE,
      bco_pkg::ST_PAIR: begin
        // Second half is not compared, so a mismatch goes unnoticed
        // First half, or the read half if both arrive together, fixes id, domain and type for the pair
        if (ar_bar_take && !st_r.got_aw) begin
          st_nxt.bar_id   = m_ar.id;
          st_nxt.bar_dom  = m_ar.domain;
          st_nxt.bar_sync = m_ar.bar[bco_pkg::BAR_SYNC_BIT];
        end else if (aw_bar_take && !st_r.got_ar) begin
          st_nxt.bar_id   = m_aw.id;
          st_nxt.bar_dom  = m_aw.domain;
          st_nxt.bar_sync = m_aw.bar[bco_pkg::BAR_SYNC_BIT];
        end
        if (ar_bar_take) begin
          st_nxt.got_ar = 1'b1;
        end
        if (aw_bar_take) begin
          st_nxt.got_aw = 1'b1;
        end
        // Both channels must deliver their half before draining
        if ((st_r.got_ar || ar_bar_take) && (st_r.got_aw || aw_bar_take)) begin
          st_nxt.st = bco_pkg::ST_DRAIN;
        end else if (ar_bar_take || aw_bar_take) begin
          st_nxt.st = bco_pkg::ST_PAIR;
        end
      end
      bco_pkg::ST_DRAIN: begin
        if (drain_ok) begin
          st_nxt.st     = bco_pkg::ST_RESP;
          st_nxt.r_pend = 1'b1;
          st_nxt.b_pend = 1'b1;
        end
      end
      bco_pkg::ST_RESP: begin
        // Master releases ordered traffic after both answers
        if (bar_r_go && m_r_ready) begin
          st_nxt.r_pend = 1'b0;
        end
        if (bar_b_go && m_b_ready) begin
          st_nxt.b_pend = 1'b0;
        end
        if (!st_nxt.r_pend && !st_nxt.b_pend) begin
          st_nxt.st      = bco_pkg::ST_IDLE;
          st_nxt.got_ar  = 1'b0;
          st_nxt.got_aw  = 1'b0;
          st_nxt.bar_cnt = st_r.bar_cnt + 16'h0001;
        end
      end
      default: begin
        st_nxt.st = bco_pkg::ST_IDLE;
      end
    endcase

    if (reg_wr && reg_addr == bco_pkg::REG_CTRL) begin
      st_nxt.drain_mem = reg_wdata[bco_pkg::CTRL_DRAIN_MEM_BIT];
    end
    // Counters clear on write; a same-cycle event still counts
    if (reg_wr && reg_addr == bco_pkg::REG_BARCNT) begin
      st_nxt.bar_cnt = st_nxt.bar_cnt - st_r.bar_cnt;
    end
    if (reg_wr && reg_addr == bco_pkg::REG_CROSS) begin
      st_nxt.cross_cnt = st_nxt.cross_cnt - st_r.cross_cnt;
    end
    if (reg_wr && reg_addr == bco_pkg::REG_MODCNT) begin
      st_nxt.mod_cnt = st_nxt.mod_cnt - st_r.mod_cnt;
    end

    if (reg_rd) begin
      case (reg_addr)
        bco_pkg::REG_CTRL: begin
          st_nxt.rdata[bco_pkg::CTRL_DRAIN_MEM_BIT] = st_r.drain_mem;
        end
        bco_pkg::REG_STATUS: begin
          st_nxt.rdata[bco_pkg::CNT_W-1:0] = rd_cnt;
          st_nxt.rdata[bco_pkg::STATUS_WR_LSB +: bco_pkg::CNT_W] = wr_cnt;
          st_nxt.rdata[bco_pkg::STATUS_BUSY_BIT] = !idle;
        end
        bco_pkg::REG_BARCNT: begin
          st_nxt.rdata[15:0] = st_r.bar_cnt;
        end
        bco_pkg::REG_CROSS: begin
          st_nxt.rdata[15:0] = st_r.cross_cnt;
        end
        bco_pkg::REG_MODCNT: begin
          st_nxt.rdata[15:0] = st_r.mod_cnt;
        end
        default: begin
          st_nxt.rdata = bco_pkg::REG_UNMAPPED;
        end
      endcase
    end
  end

  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      st_r           <= '0;
      st_r.drain_mem <= bco_pkg::CTRL_DRAIN_MEM_RST;
    end else begin
      st_r <= st_nxt;
    end
  end

  assign reg_rdata = st_r.rdata;

endmodule

// >>> verif/bco_barrier_unit_asserts.sv
// Port checks for the barrier ordering unit
`timescale 1ns/100ps
module bco_barrier_unit_asserts (
  input wire logic                       clk,
  input wire logic                       nrst,
  input wire logic                       ac_valid,
  input wire logic                       m_ar_valid,
  input wire logic                       m_ar_ready,
  input wire bco_pkg::bco_ar_t           m_ar,
  input wire logic                       s_ar_valid,
  input wire bco_pkg::bco_ar_t           s_ar,
  input wire logic                       m_aw_valid,
  input wire bco_pkg::bco_aw_t           m_aw,
  input wire logic                       s_aw_valid,
  input wire bco_pkg::bco_aw_t           s_aw,
  input wire logic                       m_w_valid,
  input wire bco_pkg::bco_w_t            m_w,
  input wire logic                       s_w_valid,
  input wire bco_pkg::bco_w_t            s_w,
  input wire logic                       s_r_valid,
  input wire logic                       s_r_ready,
  input wire bco_pkg::bco_r_t            s_r,
  input wire logic                       m_r_valid,
  input wire logic                       m_r_ready,
  input wire bco_pkg::bco_r_t            m_r
);
  default clocking cb @(posedge clk); endclocking
  default disable iff (!nrst);
  property p_snoop_idle; !ac_valid; endproperty
  a_snoop_idle: assert property (p_snoop_idle)
    else $error("snoop valid raised");
  // Stall checked in the accepting cycle and the two cycles after it
  property p_bar_hold;
    m_ar_valid && m_ar_ready && m_ar.bar[0] |-> !s_ar_valid ##1 !s_ar_valid [*2];
  endproperty
  a_bar_hold: assert property (p_bar_hold)
    else $error("read forwarded during barrier");
  property p_ar_fwd; s_ar_valid |-> m_ar_valid && !m_ar.bar[0] && s_ar == m_ar; endproperty
  a_ar_fwd: assert property (p_ar_fwd)
    else $error("read request fields altered");
  property p_aw_fwd; s_aw_valid |-> m_aw_valid && !m_aw.bar[0] && s_aw == m_aw; endproperty
  a_aw_fwd: assert property (p_aw_fwd)
    else $error("write request fields altered");
  property p_mod_fwd;
    m_ar_valid && m_ar_ready && !m_ar.bar[0] && m_ar.cache[bco_pkg::CACHE_MOD_BIT] |-> s_ar_valid;
  endproperty
  a_mod_fwd: assert property (p_mod_fwd)
    else $error("modifiable read not forwarded");
  property p_w_pass; s_w_valid == m_w_valid && s_w == m_w; endproperty
  a_w_pass: assert property (p_w_pass)
    else $error("write data altered");
  property p_r_pass; s_r_valid && s_r_ready |-> m_r_valid && m_r == s_r; endproperty
  a_r_pass: assert property (p_r_pass)
    else $error("read beat altered");
  property p_bar_beat;
    m_r_valid && m_r_ready && !s_r_ready |->
      m_r.last && m_r.resp == bco_pkg::BAR_RRESP && m_r.data == bco_pkg::BAR_RDATA;
  endproperty
  a_bar_beat: assert property (p_bar_beat)
    else $error("barrier beat malformed");
endmodule

bind bco_barrier_unit bco_barrier_unit_asserts u_chk (.*);

// >>> verif/bco_slave_model.sv
// Downstream memory model, one read and one write outstanding
`timescale 1ns/100ps
module bco_slave_model (
  input  wire logic             clk,
  input  wire logic             nrst,
  input  wire logic             stall,
  input  wire logic             s_ar_valid,
  output logic                  s_ar_ready,
  input  wire bco_pkg::bco_ar_t s_ar,
  input  wire logic             s_aw_valid,
  output logic                  s_aw_ready,
  input  wire bco_pkg::bco_aw_t s_aw,
  input  wire logic             s_w_valid,
  output logic                  s_w_ready,
  input  wire bco_pkg::bco_w_t  s_w,
  output logic                  s_r_valid,
  input  wire logic             s_r_ready,
  output bco_pkg::bco_r_t       s_r,
  output logic                  s_b_valid,
  input  wire logic             s_b_ready,
  output bco_pkg::bco_b_t       s_b
);
  logic [3:0]  rid, bid;
  logic [7:0]  rn;
  logic [31:0] rad;
  logic        rp, bp;
  assign s_ar_ready = !rp;
  assign s_aw_ready = 1'b1;
  assign s_w_ready  = 1'b1;
  assign s_r_valid  = rp && !stall;
  assign s_b_valid  = bp && !stall;
  always_comb begin
    // Upper extra response bit set so pass-through shows
    s_r = '{id: rid, data: rad ^ 32'h5a5a_5a5a, resp: 4'h8, last: rn == 8'h00};
    if (!s_r_valid) s_r.data = ~s_r.data;
    s_b = '{id: bid, resp: 2'h0};
  end
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      {rp, bp, rid, bid, rn, rad} <= '0;
    end else begin
      if (s_ar_valid && s_ar_ready) begin
        {rp, rid, rad, rn} <= {1'b1, s_ar.id, s_ar.addr, s_ar.len};
      end else if (s_r_valid && s_r_ready) begin
        if (rn == 8'h00) rp <= 1'b0;
        else rn <= rn - 8'h01;
      end
      if (s_aw_valid) bid <= s_aw.id;
      if (s_w_valid && s_w.last) bp <= 1'b1;
      else if (s_b_valid && s_b_ready) bp <= 1'b0;
    end
  end
endmodule

// >>> verif/coherent_barrier_ordering_test.sv
// Directed bench for the barrier ordering unit
`timescale 1ns/100ps
module coherent_barrier_ordering_test;
  logic clk, nrst, stall, m_ar_valid, m_ar_ready, m_aw_valid, m_aw_ready, m_w_valid;
  logic m_w_ready, m_r_valid, m_r_ready, m_b_valid, m_b_ready, ac_valid, s_ar_valid;
  logic s_ar_ready, s_aw_valid, s_aw_ready, s_w_valid, s_w_ready, s_r_valid, s_r_ready;
  logic s_b_valid, s_b_ready, reg_wr, reg_rd;
  logic [7:0]        reg_addr;
  logic [31:0]       reg_wdata, reg_rdata, d;
  bco_pkg::bco_ar_t  m_ar, s_ar;
  bco_pkg::bco_aw_t  m_aw, s_aw;
  bco_pkg::bco_w_t   m_w, s_w;
  bco_pkg::bco_r_t   m_r, s_r, rr;
  bco_pkg::bco_b_t   m_b, s_b, bb;
  int errors, comparisons, cyc;
  // Snoop code standing for the maintainer's sync message; value arbitrary
  localparam logic [3:0] VM_SYNC = 4'hf;

  bco_barrier_unit u_dut (.*);
  bco_slave_model  u_slv (.*);

  initial begin
    clk = 1'b0;
    forever #12.5 clk = ~clk;
  end

  task automatic report_and_stop();
    $display("errors %0d comparisons %0d", errors, comparisons);
    if (errors == 0 && comparisons > 0) begin
      $display("[ PASS ]");
    end else begin
      $display("[ FAIL ]");
    end
    $finish;
  endtask

  // Run should need well under a thousand cycles
  always @(posedge clk) begin
    cyc++;
    if (cyc == 4000) begin
      errors++;
      $display("ERROR %0t: timeout", $time);
      report_and_stop();
    end
  end

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    comparisons++;
    if (got !== exp) begin
      errors++;
      $display("ERROR %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  function automatic bco_pkg::bco_ar_t mk_ar(logic [3:0] id, logic [31:0] a, logic [7:0] n,
                                             logic [3:0] ca, logic [1:0] dm, logic [1:0] br);
    mk_ar = {id, a, n, 3'h2, 2'h1, ca, 4'h0, dm, br};
  endfunction

  // Write side copies id, domain and barrier type of the read side
  function automatic bco_pkg::bco_aw_t mk_aw(bco_pkg::bco_ar_t a);
    mk_aw = {a.id, a.addr, a.len, a.size, a.burst, a.cache, 3'h0, a.domain, a.bar, 1'b1};
  endfunction

  task automatic wr(input logic [7:0] a, input logic [31:0] v);
    reg_addr <= a;
    reg_wdata <= v;
    reg_wr <= 1'b1;
    @(posedge clk);
    reg_wr <= 1'b0;
  endtask

  task automatic rd(input logic [7:0] a);
    reg_addr <= a;
    reg_rd <= 1'b1;
    @(posedge clk);
    reg_rd <= 1'b0;
    @(posedge clk);
    d = reg_rdata;
  endtask

  // Leading edge keeps valids from being set twice in one step
  task automatic send(input logic a, input logic b, input logic c);
    @(posedge clk);
    m_ar_valid <= a;
    m_aw_valid <= b;
    m_w_valid <= c;
    for (int i = 0; i < 40 && (a || b || c); i++) begin
      @(posedge clk);
      if (m_ar_ready === 1'b1) a = 1'b0;
      if (m_aw_ready === 1'b1) b = 1'b0;
      if (m_w_ready === 1'b1) c = 1'b0;
      m_ar_valid <= a;
      m_aw_valid <= b;
      m_w_valid <= c;
    end
    chk(32'(a | b | c), 32'h0);
  endtask

  task automatic wait_r();
    m_r_ready <= 1'b1;
    for (int i = 0; i < 60; i++) begin
      @(posedge clk);
      if (m_r_valid === 1'b1) break;
    end
    rr = m_r;
    chk(32'(m_r_valid), 32'h1);
  endtask

  task automatic wait_b();
    m_b_ready <= 1'b1;
    for (int i = 0; i < 60; i++) begin
      @(posedge clk);
      if (m_b_valid === 1'b1) break;
    end
    bb = m_b;
    chk(32'(m_b_valid), 32'h1);
  endtask

  task automatic t_read();
    m_ar <= mk_ar(4'h2, 32'h0000_0ffc, 8'h01, 4'h2, 2'h2, 2'h0);
    send(1'b1, 1'b0, 1'b0);
    wait_r();
    chk(rr.data, 32'h0000_0ffc ^ 32'h5a5a_5a5a);
    chk(32'(rr.resp[3:2]), 32'h2);
    wait_r();
    chk(32'(rr.last), 32'h1);
    rd(bco_pkg::REG_MODCNT);
    chk(d, 32'h1);
    rd(bco_pkg::REG_CROSS);
    chk(d, 32'h1);
    rd(8'h20);
    chk(d, bco_pkg::REG_UNMAPPED);
    $display("test read done");
  endtask

  task automatic t_write();
    m_aw <= mk_aw(mk_ar(4'h5, 32'h0000_0100, 8'h00, 4'h0, 2'h1, 2'h0));
    m_w <= '{data: 32'hc0de_0001, strb: 4'hf, last: 1'b1};
    send(1'b0, 1'b1, 1'b1);
    wait_b();
    chk(32'(bb.id), 32'h5);
    chk(32'(bb.resp), 32'h0);
    $display("test write done");
  endtask

  task automatic t_membar();
    m_r_ready <= 1'b0;
    m_b_ready <= 1'b0;
    m_ar <= mk_ar(4'h7, 32'h0, 8'h00, 4'h0, 2'h2, 2'h1);
    m_aw <= mk_aw(mk_ar(4'h7, 32'h0, 8'h00, 4'h0, 2'h2, 2'h1));
    send(1'b1, 1'b1, 1'b0);
    @(posedge clk);
    m_ar <= mk_ar(4'h1, 32'h0000_0040, 8'h00, 4'h0, 2'h2, 2'h0);
    m_ar_valid <= 1'b1;
    // Answers held back, so later read must stay stalled
    repeat (3) begin
      @(posedge clk);
      chk(32'(m_ar_ready), 32'h0);
    end
    wait_r();
    chk(32'(rr.id), 32'h7);
    chk(rr.data, bco_pkg::BAR_RDATA);
    chk({27'h0, rr.resp, rr.last}, {27'h0, bco_pkg::BAR_RRESP, 1'b1});
    wait_b();
    chk(32'(bb.id), 32'h7);
    // Stalled read goes out on the edge after both answers are taken
    @(posedge clk);
    chk(32'(m_ar_ready), 32'h1);
    m_ar_valid <= 1'b0;
    wait_r();
    chk(rr.data, 32'h0000_0040 ^ 32'h5a5a_5a5a);
    rd(bco_pkg::REG_BARCNT);
    chk(d, 32'h1);
    $display("test memory barrier done");
  endtask

  task automatic t_syncbar();
    m_b_ready <= 1'b0;
    stall <= 1'b1;
    m_ar <= mk_ar(4'h3, 32'h0000_0080, 8'h00, 4'h0, bco_pkg::DOM_SYSTEM, 2'h0);
    send(1'b1, 1'b0, 1'b0);
    m_ar <= mk_ar(4'h9, 32'h0, 8'h00, 4'h0, bco_pkg::DOM_SYSTEM, 2'h3);
    m_aw <= mk_aw(mk_ar(4'h9, 32'h0, 8'h00, 4'h0, bco_pkg::DOM_SYSTEM, 2'h3));
    send(1'b1, 1'b1, 1'b0);
    // Earlier read still at the slave, so no answer yet
    repeat (8) begin
      @(posedge clk);
      chk(32'(m_r_valid), 32'h0);
    end
    stall <= 1'b0;
    wait_r();
    chk(32'(rr.id), 32'h3);
    wait_r();
    chk({28'h0, rr.id}, 32'h9);
    wait_b();
    chk(32'(bb.id), 32'h9);
    rd(bco_pkg::REG_BARCNT);
    chk(d, 32'h2);
    wr(bco_pkg::REG_BARCNT, 32'h0);
    rd(bco_pkg::REG_BARCNT);
    chk(d, 32'h0);
    $display("test sync barrier done");
  endtask

  // Memory barrier with full drain asked for by software
  task automatic t_drainbar();
    m_b_ready <= 1'b0;
    wr(bco_pkg::REG_CTRL, 32'h0000_0001);
    rd(bco_pkg::REG_CTRL);
    chk(d, 32'h0000_0001);
    stall <= 1'b1;
    m_ar <= '{id: 4'h6, addr: 32'h0000_00c0, len: 8'h00, size: 3'h2, burst: 2'h1,
              cache: 4'h0, snoop: VM_SYNC, domain: 2'h2, bar: 2'h0};
    send(1'b1, 1'b0, 1'b0);
    m_ar <= mk_ar(4'ha, 32'h0, 8'h00, 4'h0, 2'h2, 2'h1);
    m_aw <= mk_aw(mk_ar(4'ha, 32'h0, 8'h00, 4'h0, 2'h2, 2'h1));
    send(1'b1, 1'b1, 1'b0);
    repeat (4) begin
      @(posedge clk);
      chk(32'(m_r_valid), 32'h0);
    end
    rd(bco_pkg::REG_STATUS);
    chk(d, 32'h0001_0001);
    stall <= 1'b0;
    wait_r();
    chk(32'(rr.id), 32'h6);
    wait_r();
    chk(32'(rr.id), 32'ha);
    wait_b();
    chk(32'(bb.id), 32'ha);
    wr(bco_pkg::REG_CTRL, 32'h0000_0000);
    $display("test drained barrier done");
  endtask

  initial begin
    {nrst, stall, m_ar_valid, m_aw_valid, m_w_valid, m_r_ready, m_b_ready} = '0;
    {reg_wr, reg_rd, reg_addr, reg_wdata} = '0;
    m_ar = '0;
    m_aw = '0;
    m_w = '0;
    repeat (10) @(posedge clk);
    chk(32'(ac_valid), 32'h0);
    nrst <= 1'b1;
    @(posedge clk);
    t_read();
    t_write();
    t_membar();
    t_syncbar();
    t_drainbar();
    report_and_stop();
  end
endmodule
